// ==== logic/dcc_top.sv ====
// dual capture/compare unit working against the sixteen-bit timer count
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module dcc_top (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] timer_count_i,
  input wire logic capture_input_pin_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic [1:0] compare_output_pin_o,
  output logic [1:0] compare_drive_en_o,
  output logic special_event_o
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  // software-visible state
  logic [7:0] dual_mode_control_r;
  logic [15:0] set_compare_value_r [2];
  // per-set running state
  logic [3:0] pre_cnt_r [2];
  logic [1:0] set_interrupt_flag_r;
  logic [1:0] cmp_latch_r;
  logic [1:0] was_off_r;
  logic [1:0] match_prev_r;
  // capture pin pipeline
  logic pin_meta_r;
  logic pin_sync_r;
  logic pin_prev_r;
  // combinational decode
  logic rise;
  logic fall;
  logic [3:0] mode [2];
  logic [1:0] capt_evt;
  logic [1:0] match_evt;
  logic [1:0] match_now;

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // mode field of one set
  function automatic logic [3:0] set_mode(input logic [7:0] ctl, input int s);
    set_mode = (s == 0) ? ctl[dcc_pkg::SET1_MODE_LSB +: dcc_pkg::MODE_W]
                        : ctl[dcc_pkg::SET2_MODE_LSB +: dcc_pkg::MODE_W];
  endfunction : set_mode

  // true when the set is in a compare mode that raises a flag
  function automatic logic cmp_flags(input logic [3:0] m);
    cmp_flags = m[3] && (m != dcc_pkg::M_CMP_RSV);
  endfunction : cmp_flags

  // register index of one byte of a set's value: sets sit side by side, low byte first
  function automatic logic [2:0] value_addr(input int s, input logic hi);
    value_addr = hi ? 3'(dcc_pkg::ADDR_S1_HI + 2 * s) : 3'(dcc_pkg::ADDR_S1_LO + 2 * s);
  endfunction : value_addr

  // flag register image: only the two set flags exist, the overflow bit stays 0
  function automatic logic [7:0] flag_image(input logic [1:0] f);
    flag_image = 8'h00;
    flag_image[dcc_pkg::SET1_FLAG_BIT] = f[0];
    flag_image[dcc_pkg::SET2_FLAG_BIT] = f[1];
    flag_image[dcc_pkg::TMR_OVF_BIT] = 1'b0;
  endfunction : flag_image

  // ---------------------------------------------------------------
  // capture pin synchroniser and edge detection
  // ---------------------------------------------------------------
  // two flops against metastability; only the second one feeds the edge logic
  // the pin is sampled whatever its direction, so a port write that moves
  // the level is seen like an external edge
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
      pin_prev_r <= 1'b0;
    end
    else
    begin
      pin_meta_r <= capture_input_pin_i;
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
    end
  end

  assign rise = pin_sync_r && !pin_prev_r;
  assign fall = !pin_sync_r && pin_prev_r;

  // ---------------------------------------------------------------
  // per-set event decode
  // ---------------------------------------------------------------
  // the count is used as it arrives: the timer's clock source is chosen where the
  // timer lives, so a too-fast source only shows up here as skipped counts
  // reserved code 1011 sees equality but neither flags nor drives anything
  always_comb
  begin
    for (int s = 0; s < 2; s++)
    begin
      mode[s] = set_mode(dual_mode_control_r, s);
      match_now[s] = mode[s][3] && (set_compare_value_r[s] == timer_count_i);
      // edge of the match only: the timer may sit on one count for several clocks
      match_evt[s] = match_now[s] && !match_prev_r[s] && cmp_flags(mode[s]);
      unique case (mode[s])
        dcc_pkg::M_CAP_FALL: capt_evt[s] = fall;
        dcc_pkg::M_CAP_RISE: capt_evt[s] = rise;
        dcc_pkg::M_CAP_4TH:
          capt_evt[s] = rise && ((pre_cnt_r[s] & dcc_pkg::PRE_MASK_4) == dcc_pkg::PRE_LAST_4);
        dcc_pkg::M_CAP_16TH: capt_evt[s] = rise && (pre_cnt_r[s] == dcc_pkg::PRE_LAST_16);
        default: capt_evt[s] = 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // edge prescalers
  // ---------------------------------------------------------------
  // switching between capture codes keeps the count on purpose, so the
  // first capture after such a switch may come early
  // limitation: that early capture also raises the flag, so software should
  // pass through off before picking another capture code
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int s = 0; s < 2; s++)
        pre_cnt_r[s] <= dcc_pkg::PRE_RST;
    end
    else
    begin
      for (int s = 0; s < 2; s++)
      begin
        if (mode[s][3:2] != dcc_pkg::GRP_CAPT)
          pre_cnt_r[s] <= dcc_pkg::PRE_RST;
        else if (rise)
          pre_cnt_r[s] <= pre_cnt_r[s] + 4'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // mode register and value registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      dual_mode_control_r <= dcc_pkg::MODE_RST;
    else if (reg_wr_i && (reg_addr_i == dcc_pkg::ADDR_MODE))
      dual_mode_control_r <= reg_wdata_i;
  end

  // a capture in the same cycle as a byte write wins: the fresh count matters more
  // bytes are written one at a time with no shadow latch, so software that reads
  // a set while captures keep coming may see the halves of two different counts
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      set_compare_value_r[0] <= dcc_pkg::VALUE_RST;
      set_compare_value_r[1] <= dcc_pkg::VALUE_RST;
    end
    else
    begin
      for (int s = 0; s < 2; s++)
      begin
        if (capt_evt[s])
          set_compare_value_r[s] <= timer_count_i;
        else if (reg_wr_i && (reg_addr_i == value_addr(s, 1'b0)))
          set_compare_value_r[s][7:0] <= reg_wdata_i;
        else if (reg_wr_i && (reg_addr_i == value_addr(s, 1'b1)))
          set_compare_value_r[s][15:8] <= reg_wdata_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt flags
  // ---------------------------------------------------------------
  // writing 0 to a flag bit clears it; a set in the same cycle wins.
  // the timer overflow bit is never driven here, special events included
  // trade-off: a clear that meets a set is lost; losing an event would be worse
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      set_interrupt_flag_r <= 2'h0;
    else
    begin
      for (int s = 0; s < 2; s++)
      begin
        if (capt_evt[s] || match_evt[s])
          set_interrupt_flag_r[s] <= 1'b1;
        else if (reg_wr_i && (reg_addr_i == dcc_pkg::ADDR_FLAGS))
          set_interrupt_flag_r[s] <= (s == 0) ? reg_wdata_i[dcc_pkg::SET1_FLAG_BIT]
                                              : reg_wdata_i[dcc_pkg::SET2_FLAG_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // compare output latches, pin enables and special event
  // ---------------------------------------------------------------
  // the latch is cleared while off; entering clear-on-match from off loads 1
  // one edge later, and that preset overrides a match falling in the same cycle
  // the pin is claimed only in the three modes that act on it
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cmp_latch_r <= 2'h0;
      was_off_r <= 2'h3;
      match_prev_r <= 2'h0;
      compare_drive_en_o <= 2'h0;
    end
    else
    begin
      for (int s = 0; s < 2; s++)
      begin
        match_prev_r[s] <= match_now[s];
        was_off_r[s] <= (mode[s][3:2] == dcc_pkg::GRP_OFF);
        compare_drive_en_o[s] <= (mode[s] == dcc_pkg::M_CMP_SET) ||
                                 (mode[s] == dcc_pkg::M_CMP_CLR) ||
                                 (mode[s] == dcc_pkg::M_CMP_TGL);
        if (mode[s][3:2] == dcc_pkg::GRP_OFF)
          cmp_latch_r[s] <= 1'b0;
        else if (was_off_r[s] && (mode[s] == dcc_pkg::M_CMP_CLR))
          cmp_latch_r[s] <= 1'b1;
        else if (match_evt[s])
        begin
          unique case (mode[s])
            dcc_pkg::M_CMP_SET: cmp_latch_r[s] <= 1'b1;
            dcc_pkg::M_CMP_CLR: cmp_latch_r[s] <= 1'b0;
            dcc_pkg::M_CMP_TGL: cmp_latch_r[s] <= !cmp_latch_r[s];
            default: cmp_latch_r[s] <= cmp_latch_r[s];
          endcase
        end
      end
    end
  end

  assign compare_output_pin_o = cmp_latch_r;

  // one-clock trigger; the timer is an input here, so it is never reset
  // both sets share the one trigger line, so matches of both in one cycle give a single pulse
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      special_event_o <= 1'b0;
    else
      special_event_o <= (match_evt[0] && (mode[0] == dcc_pkg::M_CMP_EVT)) ||
                         (match_evt[1] && (mode[1] == dcc_pkg::M_CMP_EVT));
  end

  // ---------------------------------------------------------------
  // read port: data only in the cycle after the strobe
  // ---------------------------------------------------------------
  // zero outside the answer cycle, so read data of several blocks can be or-ed
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      reg_rdata_o <= 8'h00;
    else if (!reg_rd_i)
      reg_rdata_o <= 8'h00;
    else
    begin
      unique case (reg_addr_i)
        dcc_pkg::ADDR_MODE: reg_rdata_o <= dual_mode_control_r;
        dcc_pkg::ADDR_S1_LO: reg_rdata_o <= set_compare_value_r[0][7:0];
        dcc_pkg::ADDR_S1_HI: reg_rdata_o <= set_compare_value_r[0][15:8];
        dcc_pkg::ADDR_S2_LO: reg_rdata_o <= set_compare_value_r[1][7:0];
        dcc_pkg::ADDR_S2_HI: reg_rdata_o <= set_compare_value_r[1][15:8];
        dcc_pkg::ADDR_FLAGS:
          reg_rdata_o <= flag_image(set_interrupt_flag_r);
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end
endmodule : dcc_top

// ==== logic/dcc_pkg.sv ====
// shared constants for the dual capture/compare unit
package dcc_pkg;
  // ---------------------------------------------------------------
  // register map (index on reg_addr_i)
  // ---------------------------------------------------------------
  localparam logic [2:0] ADDR_MODE = 3'h0;
  localparam logic [2:0] ADDR_S1_LO = 3'h1;
  localparam logic [2:0] ADDR_S1_HI = 3'h2;
  localparam logic [2:0] ADDR_S2_LO = 3'h3;
  localparam logic [2:0] ADDR_S2_HI = 3'h4;
  localparam logic [2:0] ADDR_FLAGS = 3'h5;
  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int MODE_W = 4;
  localparam int SET1_MODE_LSB = 0;
  localparam int SET2_MODE_LSB = 4;
  localparam int TMR_OVF_BIT = 0;
  localparam int SET1_FLAG_BIT = 2;
  localparam int SET2_FLAG_BIT = 3;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [15:0] VALUE_RST = 16'h0000;
  localparam logic [3:0] PRE_RST = 4'h0;
  // ---------------------------------------------------------------
  // mode codes of one set
  // ---------------------------------------------------------------
  localparam logic [1:0] GRP_OFF = 2'h0;
  localparam logic [1:0] GRP_CAPT = 2'h1;
  localparam logic [3:0] M_CAP_FALL = 4'h4;
  localparam logic [3:0] M_CAP_RISE = 4'h5;
  localparam logic [3:0] M_CAP_4TH = 4'h6;
  localparam logic [3:0] M_CAP_16TH = 4'h7;
  localparam logic [3:0] M_CMP_SET = 4'h8;
  localparam logic [3:0] M_CMP_CLR = 4'h9;
  localparam logic [3:0] M_CMP_TGL = 4'hA;
  localparam logic [3:0] M_CMP_RSV = 4'hB;
  localparam logic [3:0] M_CMP_EVT = 4'hF;
  localparam logic [1:0] GRP_SWI = 2'h3;
  // prescaler terminal counts (count of rising edges minus one)
  localparam logic [3:0] PRE_LAST_4 = 4'h3;
  localparam logic [3:0] PRE_LAST_16 = 4'hF;
  localparam logic [3:0] PRE_MASK_4 = 4'h3;
endpackage : dcc_pkg

// ==== bench/dcc_chk_asserts.sv ====
// port-level checker of the dual capture/compare unit
`timescale 1ns/1ps
module dcc_chk (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [1:0] compare_output_pin_o,
  input wire logic [1:0] compare_drive_en_o,
  input wire logic special_event_o
);
  logic [7:0] mode_r;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------------------------------
  // shadow of the mode register, loaded at the same edge as the design
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      mode_r <= 8'h00;
    else if (reg_wr_i && reg_addr_i == dcc_pkg::ADDR_MODE)
      mode_r <= reg_wdata_i;
  end
  chk_rdata_idle_zero: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data not zero outside read cycle");
  chk_unmapped_read: assert property ($past(reg_rd_i && reg_addr_i[2:1] == 2'h3)
    |-> reg_rdata_o == 8'h00)
    else $error("unmapped index returned data");
  chk_off_latch: assert property (mode_r[3:2] == 2'h0 && $past(mode_r[3:2]) == 2'h0
    |-> compare_output_pin_o[0] == 1'b0 && compare_drive_en_o[0] == 1'b0)
    else $error("off mode left latch or drive set");
  chk_swi_pin_hold: assert property (mode_r[3:2] == 2'h3 && $past(mode_r[3:2]) == 2'h3
    |-> $stable(compare_output_pin_o[0]) && !compare_drive_en_o[0])
    else $error("software interrupt mode touched the pin");
  chk_set_latch: assert property (mode_r[3:0] == 4'h8 && $past(mode_r[3:0]) == 4'h8
    |-> !$fell(compare_output_pin_o[0]) && compare_drive_en_o[0])
    else $error("set-on-match latch fell");
  chk_clr_latch: assert property (mode_r[3:0] == 4'h9 && $past(mode_r[3:0]) == 4'h9
    && $past(mode_r[3:0], 2) == 4'h9 |-> !$rose(compare_output_pin_o[0]))
    else $error("clear-on-match latch rose");
  chk_event_mode: assert property (special_event_o
    |-> $past(mode_r[3:0]) == 4'hF || $past(mode_r[7:4]) == 4'hF)
    else $error("special event outside event mode");
  chk_event_once: assert property (special_event_o |=> !special_event_o)
    else $error("special event longer than one cycle");
endmodule : dcc_chk
bind dcc_top dcc_chk dcc_chk_inst (.ref_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .reg_rd_i, .reg_rdata_o, .compare_output_pin_o, .compare_drive_en_o,
  .special_event_o);

// ==== bench/dcc_far_side.sv ====
// far-side model: sixteen-bit timer and capture event source
`timescale 1ns/1ps
module dcc_far_side (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic tmr_run_i,
  input wire logic tmr_load_i,
  input wire logic [15:0] tmr_val_i,
  input wire logic pin_level_i,
  output logic [15:0] timer_count_o,
  output logic capture_input_pin_o
);
  // timer ticks on the instruction clock only; a faster source would only show up at the unit as skipped counts
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      timer_count_o <= 16'h0000;
    else if (tmr_load_i)
      timer_count_o <= tmr_val_i;
    else if (tmr_run_i)
      timer_count_o <= timer_count_o + 16'h0001;
  end
  // pin kept as an input, so only the event source moves it
  assign capture_input_pin_o = pin_level_i;
endmodule : dcc_far_side

// ==== bench/dcc_top_bench.sv ====
// self-checking bench of the dual capture/compare unit
`timescale 1ns/1ps
module dcc_top_bench;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic run = 1'b1;
  logic load = 1'b0;
  logic [15:0] tval = 16'h0000;
  logic pin = 1'b0;
  logic [15:0] tcnt;
  logic cap_pin;
  logic [7:0] rdata;
  logic [1:0] cpin;
  logic [1:0] cen;
  logic sev;
  logic [15:0] v;
  logic [3:0] e;
  logic [3:0] cmp_modes [6] = '{4'h8, 4'h9, 4'hA, 4'hC, 4'hF, 4'hB};
  int n_fail = 0;
  int compares = 0;
  int n_evt = 0;
  int seed = 32'h1927;
  // 10 MHz clock
  always #50 ref_clk_i = ~ref_clk_i;
  dcc_far_side dcc_far_side_inst (.ref_clk_i, .rst_n_i, .tmr_run_i(run), .tmr_load_i(load),
    .tmr_val_i(tval), .pin_level_i(pin), .timer_count_o(tcnt), .capture_input_pin_o(cap_pin));
  dcc_top dcc_top_inst (.ref_clk_i, .rst_n_i, .timer_count_i(tcnt),
    .capture_input_pin_i(cap_pin), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .compare_output_pin_o(cpin),
    .compare_drive_en_o(cen), .special_event_o(sev));
  // ----------------------------------------------------------------
  // bus cycles and helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic ticks(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : ticks
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask : rd_chk
  task automatic load_tmr(input logic [15:0] t);
    @(posedge ref_clk_i);
    tval <= t;
    load <= 1'b1;
    @(posedge ref_clk_i);
    load <= 1'b0;
  endtask : load_tmr
  // each edge is held six cycles, well past the input synchroniser
  task automatic rises(input int n);
    repeat (n)
    begin
      pin <= 1'b1;
      ticks(6);
      pin <= 1'b0;
      ticks(6);
    end
  endtask : rises
  // expected {event, flag, drive, latch} after one match entered from off
  function automatic logic [3:0] exp_cmp(input logic [3:0] md);
    logic ok;
    ok = md != dcc_pkg::M_CMP_RSV;
    return {md == dcc_pkg::M_CMP_EVT, ok, ok && md[3:2] == 2'h2,
      md == dcc_pkg::M_CMP_SET || md == dcc_pkg::M_CMP_TGL};
  endfunction : exp_cmp
  task automatic tally_and_finish();
    $display("n_fail %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  // watchdog well beyond the fewer than one thousand cycles the tests need
  initial
  begin
    #5000000;
    n_fail++;
    tally_and_finish();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    ticks(3);
    rst_n_i <= 1'b1;
    for (int a = 0; a < 8; a++)
      rd_chk(a[2:0], 8'h00);
    for (int a = 1; a < 5; a++)
    begin
      v = 16'($random(seed));
      wr_reg(a[2:0], v[7:0]);
      rd_chk(a[2:0], v[7:0]);
    end
    wr_reg(3'h6, 8'hFF);
    rd_chk(3'h6, 8'h00);
    run <= 1'b0;
    wr_reg(dcc_pkg::ADDR_MODE, 8'h45);
    rd_chk(dcc_pkg::ADDR_MODE, 8'h45);
    wr_reg(dcc_pkg::ADDR_FLAGS, 8'h00);
    v = 16'($random(seed));
    load_tmr(v);
    pin <= 1'b1;
    ticks(6);
    rd_chk(dcc_pkg::ADDR_S1_LO, v[7:0]);
    rd_chk(dcc_pkg::ADDR_S1_HI, v[15:8]);
    rd_chk(dcc_pkg::ADDR_FLAGS, 8'h04);
    load_tmr(~v);
    pin <= 1'b0;
    ticks(6);
    rd_chk(dcc_pkg::ADDR_S2_HI, ~v[15:8]);
    rd_chk(dcc_pkg::ADDR_S1_LO, v[7:0]);
    rd_chk(dcc_pkg::ADDR_FLAGS, 8'h0C);
    v = v + 16'h1234;
    load_tmr(v);
    pin <= 1'b1;
    ticks(6);
    rd_chk(dcc_pkg::ADDR_S1_HI, v[15:8]);
    pin <= 1'b0;
    run <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      wr_reg(dcc_pkg::ADDR_MODE, 8'h00);
      wr_reg(dcc_pkg::ADDR_MODE, {7'h03, k[0]});
      rises(2);
      wr_reg(dcc_pkg::ADDR_MODE, 8'h00);
      wr_reg(dcc_pkg::ADDR_MODE, {7'h03, k[0]});
      wr_reg(dcc_pkg::ADDR_FLAGS, 8'h00);
      rises(k == 0 ? 3 : 15);
      rd_chk(dcc_pkg::ADDR_FLAGS, 8'h00);
      rises(1);
      rd_chk(dcc_pkg::ADDR_FLAGS, 8'h04);
    end
    foreach (cmp_modes[i])
    begin
      e = exp_cmp(cmp_modes[i]);
      // each compare mode runs on set 1, then on set 2
      for (int s = 0; s < 2; s++)
      begin
        v = 16'($random(seed));
        wr_reg(dcc_pkg::ADDR_MODE, 8'h00);
        wr_reg(dcc_pkg::ADDR_FLAGS, 8'h00);
        load_tmr(v ^ 16'h8000);
        wr_reg(3'(dcc_pkg::ADDR_S1_LO + 2 * s), v[7:0]);
        wr_reg(3'(dcc_pkg::ADDR_S1_HI + 2 * s), v[15:8]);
        wr_reg(dcc_pkg::ADDR_MODE, (s == 0) ? {4'h0, cmp_modes[i]} : {cmp_modes[i], 4'h0});
        load_tmr(v - 16'h0003);
        n_evt = 0;
        repeat (10)
        begin
          @(posedge ref_clk_i);
          #1;
          if (sev === 1'b1)
            n_evt++;
        end
        check({6'h00, cen[s], cpin[s]}, {6'h00, e[1:0]});
        check(8'(n_evt), {7'h00, e[3]});
        rd_chk(dcc_pkg::ADDR_FLAGS, (s == 0) ? {5'h00, e[2], 2'h0} : {4'h0, e[2], 3'h0});
      end
    end
    tally_and_finish();
  end
endmodule : dcc_top_bench
